// ===== logic/rtd_pkg.sv
// Shared constants and carrier types for the receive tuning and diagnostics
// pattern bank. Assumes a byte-wide register port with an 8-bit address.
package rtd_pkg;

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int CHAN_SHIFT = 5;
  localparam logic [7:0] CHAN_STRIDE = 8'h20;
  localparam logic [4:0] OFS_RX_TUNING = 5'h09;
  localparam logic [4:0] OFS_DIAG_PATTERN = 5'h0A;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POS_SLICER = 4;
  localparam int POS_EQ_WINDOW = 2;
  localparam int POS_GAIN = 0;
  localparam int POS_PATTERN = 5;
  localparam int POS_PATTERN_CLOCK_SEL = 4;
  localparam int POS_PRBS_INVERT = 3;
  localparam int POS_LOS_CRIT = 2;
  localparam int POS_AIS_EN = 1;
  localparam int POS_AUTO_ONES = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_RX_TUNING = 8'h18;
  localparam logic [7:0] RST_DIAG_PATTERN = 8'h00;

  // ----------------------------------------------------------------------
  // decode tables, indexed by field code
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLICER_PCT [4] = '{7'h28, 7'h32, 7'h3C, 7'h46};
  localparam logic [8:0] EQ_WINDOW_BITS [4] = '{9'h020, 9'h040, 9'h080, 9'h100};
  localparam logic [5:0] GAIN_DB [4] = '{6'h00, 6'h16, 6'h1A, 6'h20};

  // ----------------------------------------------------------------------
  // pattern generator constants
  // ----------------------------------------------------------------------
  localparam int PRBS_LEN = 20;
  localparam int E1_TAP_A = 14;
  localparam int E1_TAP_B = 13;
  localparam int QRSS_TAP_A = 19;
  localparam int QRSS_TAP_B = 16;
  localparam logic [3:0] QRSS_ZERO_LIMIT = 4'hE;
  localparam logic [PRBS_LEN-1:0] PRBS_SEED = 20'hFFFFF;
  localparam logic [2:0] INBAND_MIN_LEN = 3'h5;

  typedef enum logic [1:0] {
    RTD_PATT_NORMAL = 2'h0,
    RTD_PATT_ONES = 2'h1,
    RTD_PATT_PRBS = 2'h2,
    RTD_PATT_INBAND = 2'h3
  } rtd_pattern_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] slicer_threshold_sel;
    logic [1:0] eq_observe_window_sel;
    logic [1:0] monitor_gain_sel;
  } rtd_tuning_t;

  typedef struct packed {
    logic reserved;
    rtd_pattern_t tx_pattern_sel;
    logic pattern_clock_sel;
    logic prbs_invert;
    logic los_ais_criterion_sel;
    logic ais_on_los_enable;
    logic auto_all_ones_on_los;
  } rtd_diag_t;

  typedef struct packed {
    logic pos;
    logic neg;
    logic clk;
  } rtd_rail_t;

endpackage : rtd_pkg

// ===== logic/rtd_prbs_gen.sv
// Pseudo-random pattern source: 2^15-1 in E1 mode, 2^20-1 with zero
// suppression otherwise. Advances one bit per step pulse.
module rtd_prbs_gen (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic step_i,
  input wire logic e1_mode_i,
  output logic bit_o
);

  logic [rtd_pkg::PRBS_LEN-1:0] lfsr;
  logic [3:0] zero_run;
  logic fb;

  always_comb begin
    if (e1_mode_i) begin
      fb = lfsr[rtd_pkg::E1_TAP_A] ^ lfsr[rtd_pkg::E1_TAP_B];
    end else begin
      fb = lfsr[rtd_pkg::QRSS_TAP_A] ^ lfsr[rtd_pkg::QRSS_TAP_B];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lfsr <= rtd_pkg::PRBS_SEED;
    end else if (step_i) begin
      // a stuck all-zero state can only come from a mode switch; reseed
      if (lfsr == '0) begin
        lfsr <= rtd_pkg::PRBS_SEED;
      end else begin
        lfsr <= {lfsr[rtd_pkg::PRBS_LEN-2:0], fb};
      end
    end
  end

  // qrss forces a one after fourteen zeros in a row
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zero_run <= 4'h0;
      bit_o <= 1'b0;
    end else if (step_i) begin
      if (!e1_mode_i && zero_run >= rtd_pkg::QRSS_ZERO_LIMIT) begin
        bit_o <= 1'b1;
        zero_run <= 4'h0;
      end else begin
        bit_o <= fb;
        zero_run <= fb ? 4'h0 : zero_run + 4'h1;
      end
    end
  end

endmodule : rtd_prbs_gen

// ===== logic/rtd_bank.sv
// Per-channel receive tuning and diagnostics pattern control for eight channels.
// Assumes a synchronous byte register port and sampled line-side strobes.
//
// Behaviour
// - slicer code 00..11 gives 40/50/60/70 percent threshold, reset 01
// - equalizer window code gives 32/64/128/256 bits, reset 10
// - monitor gain code gives 0/22/26/32 dB boost, reset 00
// - pattern 00 sends normal data, or all zeros when pattern clock bit set
// - pattern 01 replaces transmit data with all ones
// - pattern 10 sends 2^15-1 prbs in E1, 2^20-1 qrss otherwise
// - pattern 11 repeats the programmed inband loopback code
// - pattern clock bit picks channel transmit clock (0) or master clock (1)
// - prbs invert flips pattern before transmit and before receive checking
// - criterion bit selects default or alternate los and ais criteria
// - with ais enabled and los present, receive rails and clock carry ais
// - auto all-ones sends ones during los, only with pattern 01
// - pattern register repeated per channel at 0x0A plus 0x20 stride, resets 0
//
// Decided for this implementation: the address-and-strobe port.
module rtd_bank #(
  parameter int NUM_CHAN = rtd_pkg::NUM_CHAN
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // line and framer side
  input wire logic e1_mode_i,
  input wire logic mclk_tick_i,
  input wire logic [NUM_CHAN-1:0] chan_tx_clock_in_i,
  input wire logic [NUM_CHAN-1:0] tx_data_i,
  input wire logic [NUM_CHAN-1:0][7:0] inband_code_i,
  input wire logic [NUM_CHAN-1:0][1:0] inband_len_sel_i,
  input wire logic [NUM_CHAN-1:0] los_i,
  input wire rtd_pkg::rtd_rail_t [NUM_CHAN-1:0] rx_rail_i,
  output rtd_pkg::rtd_rail_t [NUM_CHAN-1:0] rx_rail_o,
  output logic [NUM_CHAN-1:0] rx_check_data_o,
  output logic [NUM_CHAN-1:0] line_tx_pos_o,
  output logic [NUM_CHAN-1:0] line_tx_neg_o,
  output logic [NUM_CHAN-1:0] tx_bit_strobe_o,
  // receiver settings toward the analog front end
  output logic [NUM_CHAN-1:0][6:0] slicer_pct_o,
  output logic [NUM_CHAN-1:0][8:0] eq_window_bits_o,
  output logic [NUM_CHAN-1:0][5:0] monitor_gain_db_o,
  output logic [NUM_CHAN-1:0] los_ais_criterion_sel_o
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_CHAN < 1 || NUM_CHAN > (1 << (8 - rtd_pkg::CHAN_SHIFT))) begin : g_bad_chan
    $error("NUM_CHAN must fit the three channel address bits");
  end

  if (rtd_pkg::OFS_RX_TUNING == rtd_pkg::OFS_DIAG_PATTERN) begin : g_bad_map
    $error("the two register offsets must differ");
  end

  if (32'(rtd_pkg::INBAND_MIN_LEN) + 3 > 8) begin : g_bad_inband
    $error("the longest inband code must fit the eight code bits");
  end

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  logic [2:0] addr_chan;
  logic [4:0] addr_ofs;
  logic chan_ok;

  assign addr_chan = reg_addr_i[7:rtd_pkg::CHAN_SHIFT];
  assign addr_ofs = reg_addr_i[rtd_pkg::CHAN_SHIFT-1:0];
  assign chan_ok = (32'(addr_chan) < NUM_CHAN);

  rtd_pkg::rtd_tuning_t tuning [NUM_CHAN];
  rtd_pkg::rtd_diag_t diag [NUM_CHAN];
  logic [7:0] next_rdata;

  // unmapped addresses and absent channels read zero
  always_comb begin
    next_rdata = 8'h00;
    if (chan_ok && addr_ofs == rtd_pkg::OFS_RX_TUNING) begin
      next_rdata = tuning[addr_chan];
    end else if (chan_ok && addr_ofs == rtd_pkg::OFS_DIAG_PATTERN) begin
      next_rdata = diag[addr_chan];
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic wr_sel;
    logic tclk_q;
    logic tx_tick;
    logic prbs_bit;
    logic next_bit;
    logic mark_pol;
    logic ais_on;
    logic ais_clk;
    logic ais_pol;
    logic [2:0] ib_idx;
    logic [2:0] ib_last;
    logic [2:0] next_ib_idx;
    logic next_tx_pos;
    logic next_tx_neg;
    logic next_mark_pol;
    logic next_ais_clk;
    logic next_ais_pol;
    rtd_pkg::rtd_tuning_t next_tuning;
    rtd_pkg::rtd_diag_t next_diag;
    rtd_pkg::rtd_rail_t next_rx_rail;

    assign wr_sel = reg_wr_i && chan_ok && (32'(addr_chan) == ch);

    // ----------------------------------------------------------------------
    // channel registers
    // ----------------------------------------------------------------------
    // reserved bits are dropped on write so that they always read zero
    always_comb begin
      next_tuning = tuning[ch];
      if (wr_sel && addr_ofs == rtd_pkg::OFS_RX_TUNING) begin
        next_tuning = {2'h0, reg_wdata_i[5:0]};
      end
    end

    always_comb begin
      next_diag = diag[ch];
      if (wr_sel && addr_ofs == rtd_pkg::OFS_DIAG_PATTERN) begin
        next_diag = {1'b0, reg_wdata_i[6:0]};
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        tuning[ch] <= rtd_pkg::RST_RX_TUNING;
      end else begin
        tuning[ch] <= next_tuning;
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        diag[ch] <= rtd_pkg::RST_DIAG_PATTERN;
      end else begin
        diag[ch] <= next_diag;
      end
    end

    // ----------------------------------------------------------------------
    // receiver tuning decode toward the analog front end
    // ----------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        slicer_pct_o[ch] <= 7'h00;
      end else begin
        slicer_pct_o[ch] <= rtd_pkg::SLICER_PCT[tuning[ch].slicer_threshold_sel];
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        eq_window_bits_o[ch] <= 9'h000;
      end else begin
        eq_window_bits_o[ch] <=
          rtd_pkg::EQ_WINDOW_BITS[tuning[ch].eq_observe_window_sel];
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        monitor_gain_db_o[ch] <= 6'h00;
      end else begin
        monitor_gain_db_o[ch] <= rtd_pkg::GAIN_DB[tuning[ch].monitor_gain_sel];
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        los_ais_criterion_sel_o[ch] <= 1'b0;
      end else begin
        los_ais_criterion_sel_o[ch] <= diag[ch].los_ais_criterion_sel;
      end
    end

    // ----------------------------------------------------------------------
    // bit timing: channel clock rising edge or master tick
    // ----------------------------------------------------------------------
    // the channel clock is taken as a level, so an edge tick needs the
    // previous sample; a channel clock that stops gives no further bits
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        tclk_q <= 1'b0;
      end else begin
        tclk_q <= chan_tx_clock_in_i[ch];
      end
    end

    always_comb begin
      if (diag[ch].pattern_clock_sel) begin
        tx_tick = mclk_tick_i;
      end else begin
        tx_tick = chan_tx_clock_in_i[ch] && !tclk_q;
      end
    end

    rtd_prbs_gen u_prbs (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .step_i(tx_tick),
      .e1_mode_i(e1_mode_i),
      .bit_o(prbs_bit)
    );

    // ----------------------------------------------------------------------
    // pattern selection
    // ----------------------------------------------------------------------
    // inband code walks msb first over the programmed 5..8 bit length
    assign ib_last = rtd_pkg::INBAND_MIN_LEN + {1'b0, inband_len_sel_i[ch]} - 3'h1;

    always_comb begin
      next_ib_idx = ib_idx;
      if (tx_tick) begin
        next_ib_idx = (ib_idx >= ib_last) ? 3'h0 : ib_idx + 3'h1;
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ib_idx <= 3'h0;
      end else begin
        ib_idx <= next_ib_idx;
      end
    end

    always_comb begin
      next_bit = tx_data_i[ch];
      unique case (diag[ch].tx_pattern_sel)
        rtd_pkg::RTD_PATT_NORMAL: begin
          next_bit = diag[ch].pattern_clock_sel ? 1'b0 : tx_data_i[ch];
        end
        rtd_pkg::RTD_PATT_ONES: begin
          // with auto mode the ones are held back until los
          if (diag[ch].auto_all_ones_on_los) begin
            next_bit = los_i[ch] ? 1'b1 : tx_data_i[ch];
          end else begin
            next_bit = 1'b1;
          end
        end
        rtd_pkg::RTD_PATT_PRBS: begin
          next_bit = prbs_bit ^ diag[ch].prbs_invert;
        end
        rtd_pkg::RTD_PATT_INBAND: begin
          next_bit = inband_code_i[ch][ib_last - ib_idx];
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // transmit: ami rails, updated once per bit period
    // ----------------------------------------------------------------------
    always_comb begin
      next_tx_pos = line_tx_pos_o[ch];
      next_tx_neg = line_tx_neg_o[ch];
      next_mark_pol = mark_pol;
      if (tx_tick) begin
        next_tx_pos = next_bit && !mark_pol;
        next_tx_neg = next_bit && mark_pol;
        next_mark_pol = mark_pol ^ next_bit;
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        line_tx_pos_o[ch] <= 1'b0;
        line_tx_neg_o[ch] <= 1'b0;
        mark_pol <= 1'b0;
        tx_bit_strobe_o[ch] <= 1'b0;
      end else begin
        line_tx_pos_o[ch] <= next_tx_pos;
        line_tx_neg_o[ch] <= next_tx_neg;
        mark_pol <= next_mark_pol;
        tx_bit_strobe_o[ch] <= tx_tick;
      end
    end

    // ----------------------------------------------------------------------
    // receive: ais replaces rails and clock during los
    // ----------------------------------------------------------------------
    // the ais source runs without los too, so insertion may start mid-period
    assign ais_on = diag[ch].ais_on_los_enable && los_i[ch];

    always_comb begin
      next_ais_clk = ais_clk;
      next_ais_pol = ais_pol;
      if (mclk_tick_i) begin
        next_ais_clk = !ais_clk;
        next_ais_pol = ais_pol ^ !ais_clk;
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ais_clk <= 1'b0;
        ais_pol <= 1'b0;
      end else begin
        ais_clk <= next_ais_clk;
        ais_pol <= next_ais_pol;
      end
    end

    always_comb begin
      next_rx_rail = rx_rail_i[ch];
      if (ais_on) begin
        // every bit a mark, alternating rails, free-running clock
        next_rx_rail.pos = !ais_pol;
        next_rx_rail.neg = ais_pol;
        next_rx_rail.clk = ais_clk;
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        rx_rail_o[ch] <= '0;
      end else begin
        rx_rail_o[ch] <= next_rx_rail;
      end
    end

    // the checker sees line marks after the same inversion as the transmit prbs
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        rx_check_data_o[ch] <= 1'b0;
      end else begin
        rx_check_data_o[ch] <= (rx_rail_i[ch].pos | rx_rail_i[ch].neg)
                               ^ diag[ch].prbs_invert;
      end
    end
  end

endmodule : rtd_bank

// ===== testbench/rtd_bank_monitor.sv
// Checker for the register port, channel 0 decodes and channel 0 line side.
// Assumes the bind below; writes to one register are at least two cycles apart.
module rtd_bank_monitor #(
  parameter int NUM_CHAN = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic mclk_tick_i,
  input wire logic [NUM_CHAN-1:0] chan_tx_clock_in_i,
  input wire logic [NUM_CHAN-1:0] los_i,
  input wire rtd_pkg::rtd_rail_t [NUM_CHAN-1:0] rx_rail_i,
  input wire rtd_pkg::rtd_rail_t [NUM_CHAN-1:0] rx_rail_o,
  input wire logic [NUM_CHAN-1:0] line_tx_pos_o,
  input wire logic [NUM_CHAN-1:0] line_tx_neg_o,
  input wire logic [NUM_CHAN-1:0] tx_bit_strobe_o,
  input wire logic [NUM_CHAN-1:0][6:0] slicer_pct_o,
  input wire logic [NUM_CHAN-1:0][8:0] eq_window_bits_o,
  input wire logic [NUM_CHAN-1:0][5:0] monitor_gain_db_o,
  input wire logic [NUM_CHAN-1:0] los_ais_criterion_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_quiet: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
    else $error("read data outside the read slot");
  a_slicer_decode: assert property (reg_wr_i && reg_addr_i == 8'h09 |->
    ##2 slicer_pct_o[0] == rtd_pkg::SLICER_PCT[$past(reg_wdata_i[5:4], 2)])
    else $error("slicer threshold not decoded");
  a_window_decode: assert property (reg_wr_i && reg_addr_i == 8'h09 |->
    ##2 eq_window_bits_o[0] == rtd_pkg::EQ_WINDOW_BITS[$past(reg_wdata_i[3:2], 2)])
    else $error("equalizer window not decoded");
  a_gain_decode: assert property (reg_wr_i && reg_addr_i == 8'h09 |->
    ##2 monitor_gain_db_o[0] == rtd_pkg::GAIN_DB[$past(reg_wdata_i[1:0], 2)])
    else $error("monitor gain not decoded");
  a_crit_follow: assert property (reg_wr_i && reg_addr_i == 8'h0A |->
    ##2 los_ais_criterion_sel_o[0] == $past(reg_wdata_i[2], 2))
    else $error("criterion output does not follow register");
  // a strobe needs a master tick or a sampled rising transmit clock just before
  a_strobe_cause: assert property (tx_bit_strobe_o[0] |-> $past(mclk_tick_i) ||
    ($past(chan_tx_clock_in_i[0]) && !$past(chan_tx_clock_in_i[0], 2)))
    else $error("bit strobe without a tick");
  a_rails_hold: assert property (!tx_bit_strobe_o[0] |->
    $stable(line_tx_pos_o[0]) && $stable(line_tx_neg_o[0]))
    else $error("transmit rails moved between bit ticks");
  a_rx_pass: assert property ($past(nrst_i) && !$past(los_i[0]) |->
    rx_rail_o[0] == $past(rx_rail_i[0]))
    else $error("receive rails not passed through");
endmodule : rtd_bank_monitor

bind rtd_bank rtd_bank_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (.*);

// ===== testbench/rtd_line_model.sv
// Stand-in for the line and framer side: transmit clocks and receive rails.
// Assumes one system clock; rails change every cycle so stale data shows.
module rtd_line_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  output logic [7:0] chan_tx_clock_o,
  output rtd_pkg::rtd_rail_t [7:0] rx_rail_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end
  // slow bit clock keeps edge ticks eight cycles apart
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chan_tx_clock_o[i] = cnt[2];
      rx_rail_o[i] = {cnt[0] & cnt[1], ~cnt[0] & cnt[1], cnt[0]};
    end
  end
endmodule : rtd_line_model

// ===== testbench/rtd_bank_test.sv
// Self-checking bench for the tuning and diagnostics pattern bank.
// Assumes the line model supplies transmit clocks and receive rails.
module rtd_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic e1_mode_i = 1'b1;
  logic mclk_tick_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] los_i = 8'h00;
  logic [7:0][7:0] inband_code_i = 64'h0;
  logic [7:0][1:0] inband_len_sel_i = 16'h0;
  logic [7:0] chan_tx_clock_in_i, reg_rdata_o, rx_check_data_o, los_ais_criterion_sel_o;
  logic [7:0] line_tx_pos_o, line_tx_neg_o, tx_bit_strobe_o;
  rtd_pkg::rtd_rail_t [7:0] rx_rail_i, rx_rail_o;
  logic [7:0][6:0] slicer_pct_o;
  logic [7:0][8:0] eq_window_bits_o;
  logic [7:0][5:0] monitor_gain_db_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int st, mk, cyc;
  rtd_pkg::rtd_rail_t cap;
  always #10 clock_i = ~clock_i;
  rtd_line_model u_line (.clock_i(clock_i), .nrst_i(nrst_i),
    .chan_tx_clock_o(chan_tx_clock_in_i), .rx_rail_o(rx_rail_i));
  rtd_bank u_dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd
  // collects n transmit bits of one channel, counting marks and cycles used
  task automatic run(input int ch, input int n);
    st = 0;
    mk = 0;
    for (cyc = 0; st < n && cyc < 16 * n; cyc++) begin
      @(posedge clock_i);
      mclk_tick_i <= ~mclk_tick_i;
      #1 if (tx_bit_strobe_o[ch] === 1'b1) st++;
      if ((tx_bit_strobe_o[ch] & (line_tx_pos_o[ch] | line_tx_neg_o[ch])) === 1'b1) mk++;
    end
    mclk_tick_i <= 1'b0;
    chk(st, n);
  endtask : run
  // a new setting may need a bit period to land, so two bits are dropped
  task automatic go(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    run(int'(a[7:5]), 2);
  endtask : go
  task automatic t_registers();
    logic [6:0] pct [4] = '{7'h28, 7'h32, 7'h3C, 7'h46};
    logic [8:0] win [4] = '{9'h020, 9'h040, 9'h080, 9'h100};
    logic [5:0] db [4] = '{6'h00, 6'h16, 6'h1A, 6'h20};
    for (int c = 0; c < 8; c++) begin
      rd({c[2:0], 5'h09}, 8'h18);
      rd({c[2:0], 5'h0A}, 8'h00);
      chk(slicer_pct_o[c], 7'h32);
      chk(eq_window_bits_o[c], 9'h080);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h09, {2'h3, c[1:0], c[1:0], c[1:0]});
      rd(8'h09, {2'h0, c[1:0], c[1:0], c[1:0]});
      chk(slicer_pct_o[0], pct[c]);
      chk(eq_window_bits_o[0], win[c]);
      chk(monitor_gain_db_o[0], db[c]);
    end
    wr(8'hAA, 8'hFF);
    rd(8'hAA, 8'h7F);
    chk(los_ais_criterion_sel_o, 8'h20);
    wr(8'h0A, 8'h04);
    rd(8'h0A, 8'h04);
    chk(los_ais_criterion_sel_o, 8'h21);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'h00);
    $display("register test done");
  endtask : t_registers
  task automatic t_transmit();
    go(8'h2A, 8'h30);
    run(1, 20);
    chk(mk, 20);
    chk(cyc < 60, 1'b1);
    go(8'h2A, 8'h20);
    run(1, 6);
    chk(mk, 6);
    chk(cyc > 36, 1'b1);
    tx_data_i <= 8'hFF;
    go(8'h2A, 8'h10);
    run(1, 10);
    chk(mk, 0);
    go(8'h2A, 8'h00);
    run(1, 4);
    chk(mk, 4);
    inband_code_i[1] <= 8'h01;
    go(8'h2A, 8'h70);
    run(1, 20);
    chk(mk, 4);
    inband_code_i[1] <= 8'h81;
    inband_len_sel_i[1] <= 2'h3;
    run(1, 8);
    run(1, 40);
    chk(mk, 10);
    for (int v = 0; v < 4; v++) begin
      e1_mode_i <= v[1];
      go(8'h2A, {4'h5, v[0], 3'h0});
      run(1, 60);
      chk(mk > 0 && mk < 60, 1'b1);
      #1 cap = rx_rail_i[1];
      @(posedge clock_i);
      #1 chk(rx_check_data_o[1], (cap.pos | cap.neg) ^ v[0]);
    end
    $display("transmit test done");
  endtask : t_transmit
  task automatic t_receive();
    int tg;
    logic c0;
    wr(8'h4A, 8'h02);
    los_i <= 8'h04;
    repeat (4) @(posedge clock_i);
    #1 c0 = rx_rail_o[2].clk;
    tg = 0;
    mk = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock_i);
      mclk_tick_i <= ~mclk_tick_i;
      #1 if (rx_rail_o[2].clk !== c0) tg++;
      c0 = rx_rail_o[2].clk;
      if ((rx_rail_o[2].pos | rx_rail_o[2].neg) === 1'b1) mk++;
    end
    chk(tg >= 9 && tg <= 11, 1'b1);
    chk(mk > 0, 1'b1);
    wr(8'h4A, 8'h00);
    #1 cap = rx_rail_i[2];
    @(posedge clock_i);
    #1 chk(rx_rail_o[2], cap);
    tx_data_i <= 8'h00;
    los_i <= 8'h00;
    go(8'h4A, 8'h21);
    run(2, 6);
    chk(mk, 0);
    los_i <= 8'h04;
    go(8'h4A, 8'h21);
    run(2, 6);
    chk(mk, 6);
    go(8'h4A, 8'h01);
    run(2, 6);
    chk(mk, 0);
    $display("receive test done");
  endtask : t_receive
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_registers();
    t_transmit();
    t_receive();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    end_sim();
  end
endmodule : rtd_bank_test
